// file: logic/hpc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "hpc_map.svh"
module hpc_top
  import hpc_pkg::*;
#(
  parameter int NUM_PORTS = 4
)(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // straps and configuration access
  input  wire hpc_strap_t           strap,
  input  wire hpc_cfg_req_t         cfg,
  output logic [7:0]                cfg_rdata_q,
  // upstream side
  input  wire hpc_up_speed_t        up_speed,
  input  wire logic                 up_vbus,
  input  wire hpc_link_t            link_in,
  output var hpc_link_t             link_q,
  // host port power requests and over-current pins
  input  wire logic [NUM_PORTS-1:0] pwr_req,
  input  wire logic [NUM_PORTS-1:0] oc_n,
  // downstream port controls
  output logic [NUM_PORTS-1:0]      pwr_en_q,
  output logic [NUM_PORTS-1:0]      ss_allow_q,
  output logic [NUM_PORTS-1:0]      hs_allow_q,
  output logic [NUM_PORTS-1:0]      port_enable_q,
  output logic [NUM_PORTS-1:0]      removable_q,
  output logic [NUM_PORTS-1:0]      bc_cdp_q,
  output logic [NUM_PORTS-1:0]      bc_dcp_q,
  output logic [NUM_PORTS-1:0]      oc_flag_q,
  output logic [2:0]                port_count_q
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter check
  if (NUM_PORTS < 1 || NUM_PORTS > 4) begin : g_bad_ports
    $error("NUM_PORTS must lie between 1 and 4");
  end

  localparam logic [2:0] NP3 = 3'(NUM_PORTS);

  ////////////////////////////////////////////////////////////////////////////
  // configuration state
  logic                 strap_done_q;
  logic                 gang_mode_q;
  logic [1:0]           cnt_m1_q;
  logic [NUM_PORTS-1:0] bc_en_q;
  logic [NUM_PORTS-1:0] remov_q;
  logic [NUM_PORTS-1:0] used_q;
  logic                 hold_q;
  logic                 cfg_wr_ok;
  logic [NUM_PORTS-1:0] oc_hit;
  logic [NUM_PORTS-1:0] en_mask;
  logic [NUM_PORTS-1:0] want;
  logic [2:0]           cnt_full;
  logic [2:0]           cnt_d;
  logic                 any_req;
  logic                 any_oc;
  hpc_gang_t            gang_q;
  hpc_gang_t            gang_d;
  logic [7:0]           rd_mux;

  // writes accepted once straps have been taken
  assign cfg_wr_ok = cfg.we && strap_done_q;
  assign oc_hit    = ~oc_n;

  // straps first, then loader and smbus writes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_done_q <= 1'b0;
      gang_mode_q  <= 1'b0;
      cnt_m1_q     <= 2'h3;
      bc_en_q      <= NUM_PORTS'(`HPC_RST_BCSUP);
      remov_q      <= NUM_PORTS'(`HPC_RST_REMOV);
      used_q       <= '1;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      gang_mode_q  <= strap.gang;
      cnt_m1_q     <= strap.cnt_m1;
      bc_en_q      <= strap.bc_en[NUM_PORTS-1:0];
      used_q       <= ~strap.port_dis[NUM_PORTS-1:0];
    end else if (cfg_wr_ok) begin
      case (cfg.addr)
        `HPC_OFF_DEVCFG: begin
          gang_mode_q <= cfg.wdata[`HPC_DEVCFG_GANG_BIT];
          cnt_m1_q    <= cfg.wdata[`HPC_DEVCFG_CNT_MSB:`HPC_DEVCFG_CNT_LSB];
        end
        `HPC_OFF_BCSUP: begin
          bc_en_q <= cfg.wdata[NUM_PORTS-1:0];
        end
        `HPC_OFF_REMOV: begin
          remov_q <= cfg.wdata[NUM_PORTS-1:0];
        end
        `HPC_OFF_PUSED: begin
          used_q <= cfg.wdata[NUM_PORTS-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // status and command: smbus only, loader writes dropped
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_q <= `HPC_RST_HOLD;
    end else if (cfg_wr_ok && !cfg.from_rom &&
                 cfg.addr == `HPC_OFF_STATCMD) begin
      hold_q <= cfg.wdata[`HPC_STAT_HOLD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reported port count and enabled-port mask
  always_comb begin
    cnt_full = {1'b0, cnt_m1_q} + 3'h1;
    cnt_d    = (cnt_full > NP3) ? NP3 : cnt_full;
    for (int i = 0; i < NUM_PORTS; i++) begin
      en_mask[i] = used_q[i] && (3'(i) < cnt_d);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_count_q  <= NP3;
      port_enable_q <= '0;
      removable_q   <= '0;
    end else begin
      port_count_q  <= cnt_d;
      port_enable_q <= en_mask;
      removable_q   <= remov_q & en_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-port power demand and over-current latches
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    hpc_port u_port (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .enable    (en_mask[g]),
      .pwr_req   (pwr_req[g]),
      .oc_hit    (oc_hit[g]),
      .hold      (hold_q),
      .want      (want[g]),
      .oc_flag_q (oc_flag_q[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // ganged power controller
  assign any_req = (|(en_mask & pwr_req)) && !hold_q;
  assign any_oc  = |(en_mask & oc_hit);

  always_comb begin
    gang_d = gang_q;
    case (gang_q)
      HPC_G_OFF: begin
        if (gang_mode_q && any_req && !any_oc) begin
          gang_d = HPC_G_ON;
        end
      end
      HPC_G_ON: begin
        if (!gang_mode_q) begin
          gang_d = HPC_G_OFF;
        end else if (any_oc) begin
          gang_d = HPC_G_TRIP;
        end else if (!any_req) begin
          gang_d = HPC_G_OFF;
        end
      end
      HPC_G_TRIP: begin
        if (!gang_mode_q || !any_req) begin
          gang_d = HPC_G_OFF;
        end
      end
      default: begin
        gang_d = HPC_G_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gang_q <= HPC_G_OFF;
    end else begin
      gang_q <= gang_d;
    end
  end

  // power switch enables, off from reset until asked for
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_en_q <= '0;
    end else if (gang_mode_q) begin
      pwr_en_q <= {NUM_PORTS{gang_d == HPC_G_ON}};
    end else begin
      pwr_en_q <= want;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // speed gating and charging personality
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ss_allow_q <= '0;
      hs_allow_q <= '0;
      bc_cdp_q   <= '0;
      bc_dcp_q   <= '0;
    end else begin
      ss_allow_q <= en_mask & {NUM_PORTS{up_speed == HPC_UP_SS}};
      hs_allow_q <= en_mask & {NUM_PORTS{up_speed != HPC_UP_FSLS}};
      bc_cdp_q   <= en_mask & bc_en_q & {NUM_PORTS{up_vbus}};
      bc_dcp_q   <= en_mask & bc_en_q & {NUM_PORTS{!up_vbus}};
    end
  end

  // upstream link status outputs
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_q <= '0;
    end else begin
      link_q <= link_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register readback, unmapped offsets read zero
  always_comb begin
    rd_mux = 8'h00;
    case (cfg.addr)
      `HPC_OFF_DEVCFG: begin
        rd_mux[`HPC_DEVCFG_GANG_BIT] = gang_mode_q;
        rd_mux[`HPC_DEVCFG_CNT_MSB:`HPC_DEVCFG_CNT_LSB] = cnt_m1_q;
      end
      `HPC_OFF_BCSUP: begin
        rd_mux[NUM_PORTS-1:0] = bc_en_q;
      end
      `HPC_OFF_REMOV: begin
        rd_mux[NUM_PORTS-1:0] = remov_q;
      end
      `HPC_OFF_PUSED: begin
        rd_mux[NUM_PORTS-1:0] = used_q;
      end
      `HPC_OFF_STATCMD: begin
        rd_mux[`HPC_STAT_HOLD_BIT] = hold_q;
        rd_mux[`HPC_STAT_TRIP_BIT] = (gang_q == HPC_G_TRIP);
        rd_mux[`HPC_STAT_LINK_MSB:`HPC_STAT_LINK_LSB] = link_q;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_rdata_q <= 8'h00;
    end else if (cfg.re) begin
      cfg_rdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_gang_need;
    gang_mode_q && any_req && !any_oc;
  endsequence

  sequence s_gang_held;
    s_gang_need ##0 (gang_q == HPC_G_ON);
  endsequence

  AST_SS_BLOCK: assert property (
    up_speed != HPC_UP_SS |=> ss_allow_q == '0)
    else $error("superspeed allowed without superspeed upstream");
  AST_HS_BLOCK: assert property (
    up_speed == HPC_UP_FSLS |=> hs_allow_q == '0 && ss_allow_q == '0)
    else $error("high speed allowed on full speed upstream");
  AST_COUNT_RANGE: assert property (
    strap_done_q |=> port_count_q >= 3'h1 && port_count_q <= NP3)
    else $error("reported port count out of range");
  AST_GANG_ON: assert property (
    s_gang_need ##0 (gang_q != HPC_G_TRIP) |=> &pwr_en_q)
    else $error("ganged power not applied to all ports");
  AST_GANG_HOLD: assert property (
    s_gang_held ##1 s_gang_need |=> &pwr_en_q && gang_q == HPC_G_ON)
    else $error("ganged power dropped while still needed");
  AST_GANG_OC: assert property (
    gang_mode_q && any_oc |=> pwr_en_q == '0 ##1 (gang_q != HPC_G_ON))
    else $error("ganged over-current left power on");
  AST_ROM_NO_STATCMD: assert property (
    cfg.we && cfg.from_rom && cfg.addr == `HPC_OFF_STATCMD
      |=> $stable(hold_q))
    else $error("loader changed status and command register");
  AST_BC_MODE: assert property (
    1'b1 |=> (bc_cdp_q | bc_dcp_q) == $past(en_mask & bc_en_q)
      && ($past(up_vbus) ? bc_dcp_q == '0 : bc_cdp_q == '0))
    else $error("charging personality wrong");
  AST_LINK_OUT: assert property (
    1'b1 |=> link_q == $past(link_in))
    else $error("link status outputs lag");
  AST_NO_UNASKED: assert property (
    pwr_en_q != '0 |-> $past(|pwr_req))
    else $error("port power on without a request");
  for (genvar k = 0; k < NUM_PORTS; k++) begin : g_chk
    AST_IND_FOLLOW: assert property (
      !gang_mode_q |=> pwr_en_q[k] == $past(want[k]))
      else $error("individual power does not follow request");
    AST_IND_OC: assert property (
      !gang_mode_q && en_mask[k] && oc_hit[k] |=> !pwr_en_q[k] ##1
        (!pwr_en_q[k] || $past(!oc_flag_q[k])))
      else $error("individual over-current left port powered");
  end

endmodule
`default_nettype wire

// file: logic/hpc_map.svh
`ifndef HPC_MAP_SVH
`define HPC_MAP_SVH
////////////////////////////////////////////////////////////////////////////
// configuration register offsets
`define HPC_OFF_DEVCFG      8'h05
`define HPC_OFF_BCSUP       8'h06
`define HPC_OFF_REMOV       8'h07
`define HPC_OFF_PUSED       8'h08
`define HPC_OFF_STATCMD     8'hF8
////////////////////////////////////////////////////////////////////////////
// field positions
`define HPC_DEVCFG_GANG_BIT 0
`define HPC_DEVCFG_CNT_LSB  1
`define HPC_DEVCFG_CNT_MSB  2
`define HPC_STAT_HOLD_BIT   0
`define HPC_STAT_TRIP_BIT   3
`define HPC_STAT_LINK_LSB   4
`define HPC_STAT_LINK_MSB   7
////////////////////////////////////////////////////////////////////////////
// reset values
`define HPC_RST_BCSUP       8'h00
`define HPC_RST_REMOV       8'hFF
`define HPC_RST_HOLD        1'b0
`endif

// file: logic/hpc_pkg.sv
`default_nettype none
package hpc_pkg;

  // speed capability of the upstream attachment
  typedef enum logic [1:0] {
    HPC_UP_FSLS = 2'h0,
    HPC_UP_HS   = 2'h1,
    HPC_UP_SS   = 2'h2
  } hpc_up_speed_t;

  // ganged power controller states
  typedef enum logic [2:0] {
    HPC_G_OFF  = 3'h1,
    HPC_G_ON   = 3'h2,
    HPC_G_TRIP = 3'h4
  } hpc_gang_t;

  // upstream link status group
  typedef struct packed {
    logic hs_conn;
    logic hs_susp;
    logic ss_conn;
    logic ss_susp;
  } hpc_link_t;

  // configuration access from the loader or the smbus side
  typedef struct packed {
    logic       we;
    logic       re;
    logic       from_rom;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hpc_cfg_req_t;

  // strap pins sampled after reset
  typedef struct packed {
    logic       gang;
    logic [1:0] cnt_m1;
    logic [3:0] port_dis;
    logic [3:0] bc_en;
  } hpc_strap_t;

endpackage
`default_nettype wire

// file: logic/hpc_port.sv
`timescale 1ns/1ps
`default_nettype none
module hpc_port
  import hpc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // port controls
  input  wire logic enable,
  input  wire logic pwr_req,
  input  wire logic oc_hit,
  input  wire logic hold,
  // results
  output logic      want,
  output logic      oc_flag_q
);

  ////////////////////////////////////////////////////////////////////////////
  // sticky over-current latch; set wins over a clear by a dropped request
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      oc_flag_q <= 1'b0;
    end else if (enable && oc_hit) begin
      oc_flag_q <= 1'b1;
    end else if (!pwr_req) begin
      oc_flag_q <= 1'b0;
    end
  end

  // individual power demand of this port
  assign want = enable && pwr_req && !hold && !oc_flag_q && !oc_hit;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_OC_STICKY: assert property (@(posedge core_clk) disable iff (sys_rst)
    enable && oc_hit |=> oc_flag_q && !want)
    else $error("over-current not latched");

  AST_OC_HELD: assert property (@(posedge core_clk) disable iff (sys_rst)
    oc_flag_q && pwr_req |=> oc_flag_q)
    else $error("over-current latch lost while power requested");

endmodule
`default_nettype wire

// file: tb/hpc_sw_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// far side: host power requests and the port power switches
module hpc_sw_model #(
  parameter int N = 4
)(
  // commands from the bench
  input  wire logic [N-1:0] host_req,
  input  wire logic [N-1:0] fault,
  // hub side pins
  input  wire logic [N-1:0] pwr_en,
  output logic [N-1:0]      pwr_req,
  output logic [N-1:0]      oc_n
);
  // host request level per port
  assign pwr_req = host_req;
  // a faulty load trips only while its switch is on, active low
  assign oc_n = ~(fault & pwr_en);
endmodule
`default_nettype wire

// file: tb/hpc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hpc_top_tb
  import hpc_pkg::*;
;
  localparam int N = 4;
  ////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic          core_clk = 1'b0;
  logic          sys_rst  = 1'b1;
  hpc_strap_t    strap    = 11'h300;
  hpc_cfg_req_t  cfg      = '0;
  hpc_up_speed_t up_speed = HPC_UP_SS;
  logic          up_vbus  = 1'b1;
  hpc_link_t     link_in  = '0;
  logic [N-1:0]  host_req = '0;
  logic [N-1:0]  fault    = '0;
  logic [7:0]    cfg_rdata_q;
  hpc_link_t     link_q;
  logic [N-1:0]  pwr_req, oc_n, pwr_en_q, ss_allow_q, hs_allow_q;
  logic [N-1:0]  port_enable_q, removable_q, bc_cdp_q, bc_dcp_q, oc_flag_q;
  logic [2:0]    port_count_q;
  logic [7:0]    v;
  int            miscompares = 0;
  int            n_compared  = 0;

  // free running clock
  always #20 core_clk = ~core_clk;

  hpc_top #(.NUM_PORTS(N)) dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .strap(strap), .cfg(cfg),
    .cfg_rdata_q(cfg_rdata_q), .up_speed(up_speed), .up_vbus(up_vbus),
    .link_in(link_in), .link_q(link_q), .pwr_req(pwr_req), .oc_n(oc_n),
    .pwr_en_q(pwr_en_q), .ss_allow_q(ss_allow_q), .hs_allow_q(hs_allow_q),
    .port_enable_q(port_enable_q), .removable_q(removable_q),
    .bc_cdp_q(bc_cdp_q), .bc_dcp_q(bc_dcp_q), .oc_flag_q(oc_flag_q),
    .port_count_q(port_count_q)
  );

  hpc_sw_model #(.N(N)) sw_u (
    .host_req(host_req), .fault(fault), .pwr_en(pwr_en_q),
    .pwr_req(pwr_req), .oc_n(oc_n)
  );
  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rom);
    cfg = '{we: 1'b1, re: 1'b0, from_rom: rom, addr: a, wdata: d};
    tick(1);
    cfg.we = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a);
    cfg = '{we: 1'b0, re: 1'b1, from_rom: 1'b0, addr: a, wdata: 8'h00};
    tick(1);
    v = cfg_rdata_q;
    cfg.re = 1'b0;
    tick(1);
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    tick(2);
    chk({4'h0, pwr_en_q}, 8'h00);
    chk({5'h00, port_count_q}, 8'h04);
    sys_rst = 1'b0;
    tick(3);
    chk({4'h0, pwr_en_q}, 8'h00);
    rd(8'h06);
    chk(v, 8'h00);
    rd(8'h07);
    chk(v, 8'h0F);
    rd(8'hC0);
    chk(v, 8'h00);
  endtask

  task automatic t_speed();
    for (int s = 0; s < 3; s++) begin
      up_speed = hpc_up_speed_t'(s);
      tick(1);
      chk({4'h0, ss_allow_q}, (s == 2) ? 8'h0F : 8'h00);
      chk({4'h0, hs_allow_q}, (s == 0) ? 8'h00 : 8'h0F);
    end
  endtask

  task automatic t_count();
    for (int c = 0; c < 4; c++) begin
      wr(8'h05, 8'(c << 1), 1'b0);
      chk({5'h00, port_count_q}, 8'(c + 1));
      chk({4'h0, port_enable_q}, 8'((2 << c) - 1));
    end
    wr(8'h08, 8'h0B, 1'b0);
    chk({4'h0, port_enable_q}, 8'h0B);
    wr(8'h08, 8'h0F, 1'b0);
  endtask

  task automatic t_indiv();
    host_req = 4'h5;
    tick(1);
    chk({4'h0, pwr_en_q}, 8'h05);
    fault = 4'h1;
    tick(1);
    chk({4'h0, pwr_en_q}, 8'h04);
    chk({4'h0, oc_flag_q}, 8'h01);
    fault = 4'h0;
    tick(2);
    chk({4'h0, pwr_en_q}, 8'h04);
    host_req = 4'h4;
    tick(1);
    chk({4'h0, oc_flag_q}, 8'h00);
    host_req = 4'h5;
    tick(1);
    chk({4'h0, pwr_en_q}, 8'h05);
    host_req = 4'h0;
    tick(1);
  endtask

  task automatic t_hold();
    wr(8'hF8, 8'h01, 1'b1);
    rd(8'hF8);
    chk(v, 8'h00);
    wr(8'hF8, 8'h01, 1'b0);
    rd(8'hF8);
    chk(v, 8'h01);
    host_req = 4'h1;
    tick(1);
    chk({4'h0, pwr_en_q}, 8'h00);
    host_req = 4'h0;
    wr(8'hF8, 8'h00, 1'b0);
  endtask

  task automatic t_gang();
    wr(8'h05, 8'h07, 1'b0);
    host_req = 4'h2;
    tick(1);
    chk({4'h0, pwr_en_q}, 8'h0F);
    host_req = 4'hA;
    tick(1);
    host_req = 4'h8;
    tick(1);
    chk({4'h0, pwr_en_q}, 8'h0F);
    host_req = 4'h0;
    tick(1);
    chk({4'h0, pwr_en_q}, 8'h00);
    host_req = 4'hA;
    tick(1);
    fault = 4'h4;
    tick(1);
    chk({4'h0, pwr_en_q}, 8'h00);
    fault = 4'h0;
    rd(8'hF8);
    chk(v, 8'h08);
    chk({4'h0, pwr_en_q}, 8'h00);
    host_req = 4'h0;
    tick(2);
    rd(8'hF8);
    chk(v, 8'h00);
    wr(8'h05, 8'h06, 1'b0);
  endtask

  task automatic t_charge();
    wr(8'h06, 8'h0F, 1'b0);
    chk({bc_cdp_q, bc_dcp_q}, 8'hF0);
    up_vbus = 1'b0;
    tick(1);
    chk({bc_cdp_q, bc_dcp_q}, 8'h0F);
    wr(8'h06, 8'h05, 1'b0);
    chk({bc_cdp_q, bc_dcp_q}, 8'h05);
    up_vbus = 1'b1;
    tick(1);
    chk({bc_cdp_q, bc_dcp_q}, 8'h50);
    wr(8'h07, 8'h0A, 1'b0);
    chk({4'h0, removable_q}, 8'h0A);
    rd(8'h07);
    chk(v, 8'h0A);
  endtask

  task automatic t_link();
    for (int i = 0; i < 4; i++) begin
      link_in = 4'(1 << i);
      tick(1);
      chk({4'h0, link_q}, 8'(1 << i));
      rd(8'hF8);
      chk(v, 8'(16 << i));
    end
    link_in = '0;
  endtask

  // second reset with ganged straps, two ports, port 1 disabled
  task automatic t_strap();
    strap   = 11'h521;
    sys_rst = 1'b1;
    tick(2);
    chk({4'h0, pwr_en_q}, 8'h00);
    sys_rst = 1'b0;
    tick(2);
    chk({5'h00, port_count_q}, 8'h02);
    chk({4'h0, port_enable_q}, 8'h01);
    chk({4'h0, removable_q}, 8'h01);
    chk({bc_cdp_q, bc_dcp_q}, 8'h10);
    rd(8'h05);
    chk(v, 8'h03);
    host_req = 4'h2;
    tick(1);
    chk({4'h0, pwr_en_q}, 8'h00);
    host_req = 4'h1;
    tick(1);
    chk({4'h0, pwr_en_q}, 8'h0F);
    host_req = 4'h0;
    tick(1);
    chk({4'h0, pwr_en_q}, 8'h00);
  endtask

  // main sequence
  initial begin
    t_reset();
    t_speed();
    t_count();
    t_indiv();
    t_hold();
    t_gang();
    t_charge();
    t_link();
    t_strap();
    report_and_stop();
  end

  // watchdog, well beyond the hundred or so cycles the tests need
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
